// [shared/scc_pkg.sv]
// Package for the system clock configuration block
package scc_pkg;
  // ==========================================
  // Register map
  localparam logic [3:0] SCC_CFG_OFFSET = 4'h4;
  localparam logic [31:0] SCC_CFG_RESET = 32'h00000000;
  // ==========================================
  // Field positions
  localparam int SCC_SEL_LSB = 0;
  localparam int SCC_STS_LSB = 2;
  localparam int SCC_AHB_LSB = 4;
  localparam int SCC_APB_LSB = 8;
  localparam int SCC_ADC_BIT = 14;
  localparam int SCC_PSRC_BIT = 16;
  localparam int SCC_PPRE_BIT = 17;
  localparam int SCC_MUL_LSB = 18;
  localparam int SCC_MCO_LSB = 24;
  // Software writable bits (status, ADC mirror and reserved excluded)
  localparam logic [31:0] SCC_WR_MASK = 32'h073f07f3;
  // ==========================================
  // Source codes
  localparam logic [1:0] SCC_SRC_HSI = 2'h0;
  localparam logic [1:0] SCC_SRC_HSE = 2'h1;
  localparam logic [1:0] SCC_SRC_PLL = 2'h2;
  // ==========================================
  // Switch timing: wait cycles while a switch is in progress
  localparam logic [1:0] SCC_SW_CYCLES = 2'h2;
  // Clock out codes
  localparam logic [2:0] SCC_MCO_NONE = 3'h0;
  // Switch state machine
  typedef enum logic [1:0] {
    SCC_IDLE = 2'b01,
    SCC_SWITCH = 2'b10
  } scc_state_t;
endpackage

// [shared/scc_div_if.sv]
// Interface carrying divider codes, ratios and PLL factor between modules
`timescale 1ns/10ps
interface scc_div_if;
  logic [3:0] ahb_clock_divider;
  logic [2:0] apb_clock_divider;
  logic [8:0] ahb_ratio;
  logic [4:0] apb_ratio;
  logic [4:0] pll_factor;
  modport decoder (input ahb_clock_divider, input apb_clock_divider, output ahb_ratio, output apb_ratio,
    output pll_factor);
  modport user (output ahb_clock_divider, output apb_clock_divider, input ahb_ratio, input apb_ratio,
    input pll_factor);
endinterface

// [verilog/scc_ratio_dec.sv]
// Decoder of divider codes into ratios
`timescale 1ns/10ps
module scc_ratio_dec
  import scc_pkg::*;
(
  scc_div_if.decoder dif,
  input wire logic [3:0] i_mul_code
);
  // ==========================================
  // Ratio decode
  typedef struct packed {
    logic [8:0] ahb;
    logic [4:0] apb;
    logic [4:0] mul;
  } scc_dec_t;
  scc_dec_t dec;
  // Combinational decode of all three fields
  always_comb begin
    dec = '0;
    case (dif.ahb_clock_divider)
      4'h8: dec.ahb = 9'h002;
      4'h9: dec.ahb = 9'h004;
      4'ha: dec.ahb = 9'h008;
      4'hb: dec.ahb = 9'h010;
      4'hc: dec.ahb = 9'h040;
      4'hd: dec.ahb = 9'h080;
      4'he: dec.ahb = 9'h100; // Undefined code, treated as slowest
      4'hf: dec.ahb = 9'h100;
      default: dec.ahb = 9'h001; // Top bit clear: undivided
    endcase
    case (dif.apb_clock_divider)
      3'h4: dec.apb = 5'h02;
      3'h5: dec.apb = 5'h04;
      3'h6: dec.apb = 5'h08;
      3'h7: dec.apb = 5'h10;
      default: dec.apb = 5'h01;
    endcase
    // Factor is code plus two, capped at sixteen
    if (i_mul_code == 4'hf) begin
      dec.mul = 5'h10;
    end else begin
      dec.mul = 5'({1'b0, i_mul_code} + 5'h02);
    end
  end
  assign dif.ahb_ratio = dec.ahb;
  assign dif.apb_ratio = dec.apb;
  assign dif.pll_factor = dec.mul;
endmodule

// [verilog/scc_top.sv]
// System clock select, prescaler configuration register and switch logic
// Operation
// - All fields reset to zero
// - Byte, halfword and word accesses accepted
// - Zero waits, one or two during switch
// - Selector picks internal, external or PLL
// - Security forces internal oscillator on failure/wake
// - Status field shows source actually in use
// - AHB divider codes map to ratios
// - APB divider codes map to ratios
// - ADC bit mirrors ADC configuration bit
// - PLL input select changes only PLL off
// - Predivider bit aliases second config bit
// - PLL factor is code plus two, capped at sixteen
// - Multiplier writes ignored while PLL on
// - Clock out selector drives output source
// - PLL enable held while PLL selected
`timescale 1ns/10ps
module scc_top
  import scc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  // Avalon-MM slave
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Neighbouring register bits
  input wire logic i_adc_clock_divider_alias,
  input wire logic i_pll_ext_predivider,
  output logic o_pll_ext_predivider_wr,
  output logic o_pll_ext_predivider_val,
  input wire logic i_pll_enable_bit,
  output logic o_pll_enable_hold,
  input wire logic i_css_enable,
  input wire logic i_lowpower_exit,
  input wire logic i_ext_osc_fail,
  // Clock routing controls
  output logic [1:0] o_sys_root_route,
  output logic [8:0] o_ahb_ratio,
  output logic [4:0] o_apb_ratio,
  output logic o_pll_input_select,
  output logic [4:0] o_pll_factor,
  output logic [2:0] o_clock_out_select
);
  // ==========================================
  // State
  typedef struct packed {
    logic [1:0] sel;
    logic [1:0] sts;
    logic [3:0] ahb;
    logic [2:0] apb;
    logic psrc;
    logic [3:0] mul;
    logic [2:0] mco;
    scc_state_t st;
    logic [1:0] cnt;
    logic [31:0] rdata;
    logic rdone;
    logic pwr;
    logic [31:0] pwd;
  } scc_st_t;
  scc_st_t cur_ff;
  scc_st_t nxt_cur;
  scc_div_if dif ();
  logic [31:0] reg_view; // Assembled register image
  logic [31:0] bmask; // Byte lane mask
  logic [31:0] wmerged; // Write data merged with old value
  logic hit; // Address decodes to register
  logic wait_now; // Stall request
  logic force_hsi; // Security forcing
  // ==========================================
  // Byte lane expansion function
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction
  // ==========================================
  // Ratio decoder
  assign dif.ahb_clock_divider = cur_ff.ahb;
  assign dif.apb_clock_divider = cur_ff.apb;
  scc_ratio_dec u_dec (
    .dif(dif),
    .i_mul_code(cur_ff.mul)
  );
  // ==========================================
  // Register image and decode
  always_comb begin
    reg_view = '0;
    reg_view[SCC_SEL_LSB +: 2] = cur_ff.sel;
    reg_view[SCC_STS_LSB +: 2] = cur_ff.sts;
    reg_view[SCC_AHB_LSB +: 4] = cur_ff.ahb;
    reg_view[SCC_APB_LSB +: 3] = cur_ff.apb;
    reg_view[SCC_ADC_BIT] = i_adc_clock_divider_alias;
    reg_view[SCC_PSRC_BIT] = cur_ff.psrc;
    reg_view[SCC_PPRE_BIT] = i_pll_ext_predivider;
    reg_view[SCC_MUL_LSB +: 4] = cur_ff.mul;
    reg_view[SCC_MCO_LSB +: 3] = cur_ff.mco;
  end
  assign hit = (i_avs_address == SCC_CFG_OFFSET);
  assign bmask = lane_mask(i_avs_byteenable);
  assign wmerged = (reg_view & ~(bmask & SCC_WR_MASK)) | (i_avs_writedata & bmask & SCC_WR_MASK);
  // External failure counts only while it feeds the system, directly or through the PLL
  assign force_hsi = i_css_enable & (i_lowpower_exit | (i_ext_osc_fail & ((cur_ff.sts == SCC_SRC_HSE) |
    ((cur_ff.sts == SCC_SRC_PLL) & cur_ff.psrc))));
  // Stall only while a switch runs
  assign wait_now = (cur_ff.st == SCC_SWITCH) & (i_avs_read | i_avs_write);
  // ==========================================
  // Next state
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.rdone = 1'b0;
    nxt_cur.pwr = 1'b0;
    // Read data captured in the cycle the access completes
    if (i_avs_read & ~wait_now) begin
      nxt_cur.rdata = hit ? reg_view : 32'h00000000;
    end
    // Write takes effect when not stalled
    if (i_avs_write & ~wait_now & hit) begin
      // Code 11 reserved: keep previous selector
      if (bmask[0] & (wmerged[SCC_SEL_LSB +: 2] != 2'h3)) begin
        nxt_cur.sel = wmerged[SCC_SEL_LSB +: 2];
      end
      nxt_cur.ahb = wmerged[SCC_AHB_LSB +: 4];
      nxt_cur.apb = wmerged[SCC_APB_LSB +: 3];
      if (~i_pll_enable_bit) begin
        nxt_cur.psrc = wmerged[SCC_PSRC_BIT];
        nxt_cur.mul = wmerged[SCC_MUL_LSB +: 4];
      end
      nxt_cur.mco = wmerged[SCC_MCO_LSB +: 3];
      nxt_cur.pwr = bmask[SCC_PPRE_BIT];
      nxt_cur.pwd = wmerged;
    end
    // Forced fallback overrides any selector write; only reset takes priority
    if (force_hsi) begin
      nxt_cur.sel = SCC_SRC_HSI;
    end
    // Switch sequencing
    case (cur_ff.st)
      SCC_IDLE: begin
        if (nxt_cur.sel != cur_ff.sts) begin
          nxt_cur.st = SCC_SWITCH;
          nxt_cur.cnt = SCC_SW_CYCLES;
        end
      end
      SCC_SWITCH: begin
        if (cur_ff.cnt == 2'h1) begin
          nxt_cur.sts = cur_ff.sel;
          nxt_cur.st = SCC_IDLE;
          nxt_cur.cnt = 2'h0;
        end else begin
          nxt_cur.cnt = 2'(cur_ff.cnt - 2'h1);
        end
      end
      default: begin
        nxt_cur.st = SCC_IDLE;
        nxt_cur.cnt = 2'h0;
      end
    endcase
    if (i_rst) begin
      nxt_cur = '0;
      nxt_cur.st = SCC_IDLE;
    end
  end
  // Register the state
  always_ff @(posedge i_clk) begin
    cur_ff <= nxt_cur;
  end
  // ==========================================
  // Outputs
  assign o_avs_waitrequest = wait_now;
  assign o_avs_readdata = nxt_cur.rdata;
  assign o_pll_ext_predivider_wr = cur_ff.pwr;
  assign o_pll_ext_predivider_val = cur_ff.pwd[SCC_PPRE_BIT];
  // Old source keeps running until status moves
  assign o_sys_root_route = cur_ff.sts;
  assign o_ahb_ratio = dif.ahb_ratio;
  assign o_apb_ratio = dif.apb_ratio;
  assign o_pll_input_select = cur_ff.psrc;
  assign o_pll_factor = dif.pll_factor;
  assign o_clock_out_select = cur_ff.mco;
  // Enable cannot drop while PLL selected or in use
  assign o_pll_enable_hold = (cur_ff.sel == SCC_SRC_PLL) | (cur_ff.sts == SCC_SRC_PLL);
  // ==========================================
  // Checks
  a_reset_zero: assert property (@(posedge i_clk) i_rst |=> (cur_ff.sel == 2'h0) && (cur_ff.mco == 3'h0))
    else $error("fields not zero after reset");
  a_switch_wait: assert property (@(posedge i_clk) disable iff (i_rst)
    (cur_ff.st == SCC_IDLE) |-> !o_avs_waitrequest)
    else $error("wait outside switch");
  a_wait_bound: assert property (@(posedge i_clk) disable iff (i_rst)
    o_avs_waitrequest [*2] |=> !o_avs_waitrequest)
    else $error("wait too long");
  a_force_hsi: assert property (@(posedge i_clk) disable iff (i_rst)
    force_hsi |=> cur_ff.sel == SCC_SRC_HSI)
    else $error("no forced fallback");
  a_status_follow: assert property (@(posedge i_clk) disable iff (i_rst)
    $changed(cur_ff.sts) |-> $past(cur_ff.st) == SCC_SWITCH)
    else $error("status moved outside switch");
  a_mul_locked: assert property (@(posedge i_clk) disable iff (i_rst)
    i_pll_enable_bit |=> $stable(cur_ff.mul))
    else $error("multiplier changed with PLL on");
  a_psrc_locked: assert property (@(posedge i_clk) disable iff (i_rst)
    i_pll_enable_bit |=> $stable(cur_ff.psrc))
    else $error("input select changed with PLL on");
  a_sel_valid: assert property (@(posedge i_clk) disable iff (i_rst) cur_ff.sts != 2'h3)
    else $error("status shows reserved code");
  a_pll_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    (cur_ff.sts == SCC_SRC_PLL) |-> o_pll_enable_hold)
    else $error("PLL enable not held");
endmodule

// [verif/test_scc_top.sv]
// Self-checking bench for the system clock configuration block
`timescale 1ns/10ps
module test_scc_top;
  import scc_pkg::*;
  logic i_clk = '0, i_rst = 1'h1, i_avs_read = '0, i_avs_write = '0, i_adc_clock_divider_alias = '0;
  logic i_pll_ext_predivider = '0, i_pll_enable_bit = '0, i_css_enable = '0, i_lowpower_exit = '0, i_ext_osc_fail = '0;
  logic [3:0] i_avs_address = '0, i_avs_byteenable = '0;
  logic [31:0] i_avs_writedata = '0, o_avs_readdata, m = '0, rd;
  logic o_avs_waitrequest, o_pll_ext_predivider_wr, o_pll_ext_predivider_val, o_pll_enable_hold, o_pll_input_select;
  logic [1:0] o_sys_root_route;
  logic [8:0] o_ahb_ratio;
  logic [4:0] o_apb_ratio, o_pll_factor;
  logic [2:0] o_clock_out_select;
  int error_cnt = 0, n_compared = 0, seed = 63, w;
  scc_top u_scc_top (.i_clk, .i_rst, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
    .o_avs_readdata, .o_avs_waitrequest, .i_adc_clock_divider_alias, .i_pll_ext_predivider, .o_pll_ext_predivider_wr,
    .o_pll_ext_predivider_val, .i_pll_enable_bit, .o_pll_enable_hold, .i_css_enable, .i_lowpower_exit,
    .i_ext_osc_fail, .o_sys_root_route, .o_ahb_ratio, .o_apb_ratio, .o_pll_input_select, .o_pll_factor,
    .o_clock_out_select);
  // 50 MHz clock
  always #10 i_clk = ~i_clk;
  // ==========================================
  // Helpers
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One Avalon access, held until waitrequest is sampled low at a rising edge; counts wait cycles
  task automatic acc(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
    input bit rel, output int nw);
    nw = 0;
    i_avs_address <= a;
    i_avs_write <= wr;
    i_avs_read <= !wr;
    i_avs_writedata <= d;
    i_avs_byteenable <= be;
    @(posedge i_clk);
    while (o_avs_waitrequest !== 1'h0) begin
      nw++;
      @(posedge i_clk);
    end
    rd = o_avs_readdata;
    if (rel) begin
      i_avs_read <= 1'h0;
      i_avs_write <= 1'h0;
    end
  endtask
  // Reference model of a register write
  task automatic mwrite(input logic [31:0] d, input logic [3:0] be);
    logic [31:0] n;
    n = m;
    for (int b = 0; b < 4; b++) if (be[b]) n[b*8 +: 8] = d[b*8 +: 8];
    if (n[1:0] == 2'h3) n[1:0] = m[1:0];
    if (i_pll_enable_bit) begin
      n[16] = m[16];
      n[21:18] = m[21:18];
    end
    m = n & SCC_WR_MASK;
  endtask
  // Expected readback once any switch has settled
  function automatic logic [31:0] exp_rd();
    logic [31:0] e;
    e = m & SCC_WR_MASK;
    e[3:2] = m[1:0];
    e[14] = i_adc_clock_divider_alias;
    e[17] = i_pll_ext_predivider;
    return e;
  endfunction
  function automatic logic [31:0] ahb(input logic [3:0] c);
    if (!c[3]) return 32'h1;
    if (c[2]) return c[1:0] == 2'h0 ? 32'h40 : c[1:0] == 2'h1 ? 32'h80 : 32'h100;
    return 32'h2 << c[1:0];
  endfunction
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    acc(1'h1, a, d, be, 1'b1, w);
    if (a == SCC_CFG_OFFSET) mwrite(d, be);
    @(negedge i_clk);
    chk("pdiv_wr", o_pll_ext_predivider_wr, be[2] && a == SCC_CFG_OFFSET);
    if (be[2] && a == SCC_CFG_OFFSET) chk("pdiv_val", o_pll_ext_predivider_val, d[17]);
    @(posedge i_clk);
  endtask
  // Read the register and check every decoded output
  task automatic rdchk();
    acc(1'h0, SCC_CFG_OFFSET, '0, 4'hf, 1'b1, w);
    chk("cfg", rd, exp_rd());
    @(negedge i_clk);
    chk("route", o_sys_root_route, m[1:0]);
    chk("ahb", o_ahb_ratio, ahb(m[7:4]));
    chk("apb", o_apb_ratio, m[10] ? 32'h1 << (m[9:8] + 1) : 32'h1);
    chk("mul", o_pll_factor, m[21:18] == 4'hf ? 32'h10 : m[21:18] + 32'h2);
    chk("psrc", o_pll_input_select, m[16]);
    chk("mco", o_clock_out_select, m[26:24]);
    chk("hold", o_pll_enable_hold, m[1:0] == SCC_SRC_PLL);
    @(posedge i_clk);
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (6) @(posedge i_clk);
    i_rst <= 1'h0;
    rdchk();
    // Every divider, multiplier and clock-out code
    for (int i = 0; i < 16; i++) begin
      wr(SCC_CFG_OFFSET, {5'h0, i[2:0], 2'h0, i[3:0], 7'h0, i[2:0], i[3:0], 4'h0}, 4'hf);
      rdchk();
    end
    // Selector write followed at once by an access
    for (int s = 1; s < 4; s++) begin
      acc(1'h1, SCC_CFG_OFFSET, 32'(s % 3), 4'h1, 1'b0, w);
      chk("wr_waits", w, 32'h0);
      mwrite(32'(s % 3), 4'h1);
      acc(1'h0, SCC_CFG_OFFSET, '0, 4'hf, 1'b1, w);
      chk("sw_waits", w, SCC_SW_CYCLES);
      chk("sw_rd", rd, exp_rd());
      @(posedge i_clk);
      rdchk();
    end
    // Unmapped places
    acc(1'h0, 4'h0, '0, 4'hf, 1'b1, w);
    chk("unmapped", rd, 32'h0);
    @(posedge i_clk);
    wr(4'h8, 32'hffffffff, 4'hf);
    rdchk();
    // Random writes, lanes and PLL state
    for (int n = 0; n < 60; n++) begin
      // PLL runs only from the 4 MHz internal input with a factor of at most 12
      i_pll_enable_bit <= 1'($random(seed)) & !m[16] & (m[21:18] <= 4'ha);
      i_adc_clock_divider_alias <= 1'($random(seed));
      i_pll_ext_predivider <= 1'($random(seed));
      @(posedge i_clk);
      wr(SCC_CFG_OFFSET, $random(seed), 4'($random(seed)));
      rdchk();
    end
    // Reset in mid-run clears every field again
    i_rst <= 1'h1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'h0;
    m = '0;
    rdchk();
    // Failure with security off leaves the source alone
    i_pll_enable_bit <= 1'h0;
    wr(SCC_CFG_OFFSET, 32'h1, 4'h1);
    rdchk();
    i_ext_osc_fail <= 1'h1;
    @(posedge i_clk);
    i_ext_osc_fail <= 1'h0;
    repeat (4) @(negedge i_clk);
    chk("no_force", o_sys_root_route, SCC_SRC_HSE);
    @(posedge i_clk);
    // Wake-up and failure both force the internal oscillator
    i_css_enable <= 1'h1;
    for (int t = 0; t < 2; t++) begin
      wr(SCC_CFG_OFFSET, 32'h1, 4'h1);
      rdchk();
      i_lowpower_exit <= t[0];
      i_ext_osc_fail <= !t[0];
      @(posedge i_clk);
      i_lowpower_exit <= 1'h0;
      i_ext_osc_fail <= 1'h0;
      m[1:0] = SCC_SRC_HSI;
      w = 0;
      do begin
        @(negedge i_clk);
        w++;
      end while (o_sys_root_route !== SCC_SRC_HSI && w < 20);
      chk("forced", o_sys_root_route, SCC_SRC_HSI);
      @(posedge i_clk);
      rdchk();
    end
    // External failure leaves a PLL fed from the internal oscillator alone
    wr(SCC_CFG_OFFSET, 32'h2, 4'h1);
    rdchk();
    i_ext_osc_fail <= 1'h1;
    @(posedge i_clk);
    i_ext_osc_fail <= 1'h0;
    repeat (4) @(negedge i_clk);
    chk("pll_kept", o_sys_root_route, SCC_SRC_PLL);
    @(posedge i_clk);
    tally_and_finish();
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (6000) @(posedge i_clk);
    error_cnt++;
    tally_and_finish();
  end
endmodule
